//--- rtl/ee_defines.svh
// constants for the two-wire serial memory slave: offsets, counts, timing
// assumes a 100 MHz ref_clk; included by the top design file
//
// Contract
// RQ1 - access opens with device byte: 1010, three strap bits, read/write bit
// RQ2 - acknowledge each byte by low data line; mismatch returns to standby
// RQ3 - write takes two word address bytes, each acknowledged, then data
// RQ4 - word address is 13 bits; top three bits of first byte ignored
// RQ5 - byte write: data byte acknowledged, host stop launches programming
// RQ6 - after write stop, self-timed programming ignores all bus inputs
// RQ7 - programming lasts no longer than 5 ms from the stop
// RQ8 - page write: up to 31 more data bytes, 32 bytes per page
// RQ9 - every page data byte acknowledged; stop starts programming
// RQ10 - each write data byte increments only the low 5 address bits
// RQ11 - write address wraps within page; extra bytes overwrite earlier ones
// RQ12 - polling device byte acknowledged only once programming has finished
// RQ13 - device byte with direction bit one starts a read
// RQ14 - address counter holds last accessed address plus one, persistently
// RQ15 - read address wraps from last array byte to the first
// RQ16 - current-address read shifts out byte at counter after acknowledge
// RQ17 - random read: dummy write of address, repeated start, read byte
// RQ18 - host acknowledge makes device advance and send the next byte
// RQ19 - read ends on host no-acknowledge plus stop; device releases data
// RQ20 - protect pin high blocks programming of the upper array quarter
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH

`define EE_DEV_TYPE      4'ha
`define EE_ADDR_BITS     13
`define EE_PAGE_BITS     5
`define EE_WP_QUAD       2'h3
`define EE_FIFO_DEPTH    8
`define EE_CLK_MHZ       100
`define EE_PROG_TIME_MS  5
`define EE_PROG_CYCLES   (`EE_PROG_TIME_MS * 1000 * `EE_CLK_MHZ)

`endif

//--- rtl/ee_pkg.sv
// types shared by the serial memory slave
// assumes nothing beyond a SystemVerilog compiler
package ee_pkg;

    // bus bit engine, gray along idle-rx-ack-tx-rack
    typedef enum logic [2:0]
    {
        EE_ST_IDLE = 3'h0,
        EE_ST_RX   = 3'h1,
        EE_ST_ACK  = 3'h3,
        EE_ST_TX   = 3'h2,
        EE_ST_RACK = 3'h6
    } ee_state_t;

    // meaning of the byte in flight
    typedef enum logic [2:0]
    {
        EE_RL_DEV  = 3'h0,
        EE_RL_AHI  = 3'h1,
        EE_RL_ALO  = 3'h2,
        EE_RL_WDAT = 3'h3,
        EE_RL_RDAT = 3'h4
    } ee_role_t;

endpackage

//--- rtl/ee_fifo.sv
// small synchronous fifo with valid/ready on both sides and a flush
// assumes DEPTH is a power of two; one clock domain
`timescale 1ns/1ps
module ee_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    import ee_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             full;

    assign full      = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                       (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = (wr_ptr_reg != rd_ptr_reg);
    assign out_data  = store[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge ref_clk)
    begin
        if (in_valid && !full && !flush)
        begin
            store[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else if (flush)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            if (in_valid && !full)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (out_ready && out_valid)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

endmodule

//--- rtl/ee_serial_mem.sv
// two-wire serial memory slave: byte/page write, timed programming,
// acknowledge polling, current, random and sequential reads
// assumes scl and sda pins arrive asynchronously and are far slower than
// ref_clk; the sda wire is resolved outside from sda_oe (low when driven)
`timescale 1ns/1ps
`include "ee_defines.svh"
module ee_serial_mem #(
    parameter int ADDR_W      = `EE_ADDR_BITS,
    parameter int PAGE_W      = `EE_PAGE_BITS,
    parameter int FIFO_D      = `EE_FIFO_DEPTH,
    parameter int PROG_CYCLES = `EE_PROG_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [2:0] chip_select_straps,
    input  wire logic       write_protect,
    output logic            prog_busy
);
    import ee_pkg::*;

    localparam int PAGE_N = 2 ** PAGE_W;
    localparam int MEM_N  = 2 ** ADDR_W;
    localparam int PW     = $clog2(PROG_CYCLES + 1);
    localparam int FW     = ADDR_W + 8;
    localparam logic [PW-1:0] PROG_LAST = PW'(PROG_CYCLES - 1);
    localparam logic [PW-1:0] PAGE_END  = PW'(PAGE_N);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic [1:0] wp_sync_reg;
    logic [2:0] strap_meta_reg;
    logic [2:0] strap_reg;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_sync_reg   <= 3'h7;
            sda_sync_reg   <= 3'h7;
            wp_sync_reg    <= 2'h0;
            strap_meta_reg <= 3'h0;
            strap_reg      <= 3'h0;
        end
        else
        begin
            scl_sync_reg   <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg   <= {sda_sync_reg[1:0], sda_in};
            wp_sync_reg    <= {wp_sync_reg[0], write_protect};
            strap_meta_reg <= chip_select_straps;
            strap_reg      <= strap_meta_reg;
        end
    end

    logic scl_s;
    logic scl_d;
    logic sda_s;
    logic sda_d;
    logic wp_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_s     = scl_sync_reg[1];
    assign scl_d     = scl_sync_reg[2];
    assign sda_s     = sda_sync_reg[1];
    assign sda_d     = sda_sync_reg[2];
    assign wp_s      = wp_sync_reg[1];
    assign scl_rise  = scl_s && !scl_d;
    assign scl_fall  = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

    // ************************************************************
    // shared state and decode
    // ************************************************************
    ee_state_t          state_reg;
    ee_role_t           role_reg;
    logic [3:0]         cnt_reg;
    logic [7:0]         rx_shift_reg;
    logic [7:0]         tx_shift_reg;
    logic               more_reg;
    logic               sda_oe_reg;
    logic               sda_out_reg;
    logic               prog_busy_reg;
    logic [PW-1:0]      prog_cnt_reg;
    logic [ADDR_W-1:0]  addr_reg;
    logic [ADDR_W-9:0]  addr_hi_reg;
    logic [ADDR_W-1:0]  pf_addr_reg;
    logic               flush_reg;
    logic [7:0]         mem [MEM_N];
    logic [7:0]         page_data [PAGE_N];
    logic               page_vld [PAGE_N];

    logic               dev_match;
    logic               rx_done;
    logic               wdat_done;
    logic               load_tx;
    logic               pop;
    logic [7:0]         tx_byte;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic [FW-1:0]      fifo_out_data;
    logic               pf_valid;
    logic               any_vld;
    logic               in_page;
    logic [PAGE_W-1:0]  prog_idx;
    logic [ADDR_W-1:0]  prog_addr;
    logic               mem_we;

    assign dev_match = rx_shift_reg[7:1] ==
                       {`EE_DEV_TYPE, strap_reg}; // RQ1
    assign rx_done   = !prog_busy_reg && state_reg == EE_ST_RX &&
                       scl_fall && cnt_reg == 4'h8 &&
                       (role_reg != EE_RL_DEV || dev_match);
    assign wdat_done = rx_done && role_reg == EE_RL_WDAT;
    assign load_tx   = !prog_busy_reg && scl_fall &&
                       ((state_reg == EE_ST_ACK &&
                         role_reg == EE_RL_RDAT) ||
                        (state_reg == EE_ST_RACK && more_reg));
    assign pop       = load_tx && fifo_out_valid;
    assign tx_byte   = fifo_out_valid ? fifo_out_data[7:0] : 8'hff;
    assign sda_oe    = sda_oe_reg;
    assign sda_out   = sda_out_reg;
    assign prog_busy = prog_busy_reg;

    // ************************************************************
    // bit engine
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg    <= EE_ST_IDLE;
            role_reg     <= EE_RL_DEV;
            cnt_reg      <= 4'h0;
            rx_shift_reg <= 8'h00;
            tx_shift_reg <= 8'h00;
            more_reg     <= 1'b0;
            sda_oe_reg   <= 1'b0;
        end
        else if (prog_busy_reg)
        begin
            state_reg  <= EE_ST_IDLE; // RQ6 RQ12
            sda_oe_reg <= 1'b0;
        end
        else if (start_det)
        begin
            state_reg  <= EE_ST_RX;
            role_reg   <= EE_RL_DEV;
            cnt_reg    <= 4'h0;
            sda_oe_reg <= 1'b0;
        end
        else if (stop_det)
        begin
            state_reg  <= EE_ST_IDLE; // RQ19
            sda_oe_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                EE_ST_IDLE:
                begin
                    sda_oe_reg <= 1'b0;
                end
                EE_ST_RX:
                begin
                    if (scl_rise)
                    begin
                        rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
                        cnt_reg      <= cnt_reg + 4'h1;
                    end
                    else if (scl_fall && cnt_reg == 4'h8)
                    begin
                        if (!rx_done)
                        begin
                            state_reg <= EE_ST_IDLE; // RQ2
                        end
                        else
                        begin
                            state_reg  <= EE_ST_ACK;
                            sda_oe_reg <= 1'b1; // RQ2 RQ3 RQ5 RQ9
                            unique case (role_reg)
                                EE_RL_DEV:  role_reg <= rx_shift_reg[0] ?
                                    EE_RL_RDAT : EE_RL_AHI; // RQ13
                                EE_RL_AHI:  role_reg <= EE_RL_ALO;
                                EE_RL_ALO:  role_reg <= EE_RL_WDAT;
                                default:    role_reg <= role_reg;
                            endcase
                        end
                    end
                end
                EE_ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        cnt_reg <= 4'h0;
                        if (role_reg == EE_RL_RDAT)
                        begin
                            state_reg    <= EE_ST_TX; // RQ16
                            tx_shift_reg <= tx_byte;
                            sda_oe_reg   <= !tx_byte[7];
                        end
                        else
                        begin
                            state_reg  <= EE_ST_RX;
                            sda_oe_reg <= 1'b0;
                        end
                    end
                end
                EE_ST_TX:
                begin
                    if (scl_rise)
                    begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (cnt_reg == 4'h8)
                        begin
                            state_reg  <= EE_ST_RACK;
                            sda_oe_reg <= 1'b0;
                            more_reg   <= 1'b0;
                        end
                        else
                        begin
                            sda_oe_reg   <= !tx_shift_reg[6];
                            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                        end
                    end
                end
                EE_ST_RACK:
                begin
                    if (scl_rise)
                    begin
                        more_reg <= !sda_s;
                    end
                    else if (scl_fall)
                    begin
                        cnt_reg <= 4'h0;
                        if (more_reg)
                        begin
                            state_reg    <= EE_ST_TX; // RQ18
                            tx_shift_reg <= tx_byte;
                            sda_oe_reg   <= !tx_byte[7];
                        end
                        else
                        begin
                            state_reg  <= EE_ST_IDLE; // RQ19
                            sda_oe_reg <= 1'b0;
                        end
                    end
                end
                default:
                begin
                    state_reg  <= EE_ST_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sda_out_reg <= 1'b0;
        end
        else
        begin
            sda_out_reg <= 1'b0;
        end
    end

    // ************************************************************
    // word address counter
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_reg    <= '0;
            addr_hi_reg <= '0;
        end
        else if (rx_done && role_reg == EE_RL_AHI)
        begin
            addr_hi_reg <= rx_shift_reg[ADDR_W-9:0]; // RQ4
        end
        else if (rx_done && role_reg == EE_RL_ALO)
        begin
            addr_reg <= {addr_hi_reg, rx_shift_reg}; // RQ4
        end
        else if (wdat_done)
        begin
            addr_reg[PAGE_W-1:0] <= addr_reg[PAGE_W-1:0] + 1'b1; // RQ10 RQ11
        end
        else if (pop)
        begin
            addr_reg <= fifo_out_data[FW-1:8] + 1'b1; // RQ14 RQ15
        end
    end

    // ************************************************************
    // read prefetch into the fifo
    // ************************************************************
    assign pf_valid = !prog_busy_reg && !flush_reg;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flush_reg   <= 1'b0;
            pf_addr_reg <= '0;
        end
        else
        begin
            flush_reg <= !prog_busy_reg && (start_det ||
                         (rx_done && role_reg == EE_RL_ALO)); // RQ17
            if (flush_reg)
            begin
                pf_addr_reg <= addr_reg;
            end
            else if (pf_valid && fifo_in_ready)
            begin
                pf_addr_reg <= pf_addr_reg + 1'b1; // RQ15
            end
        end
    end

    ee_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .flush     (flush_reg),
        .in_valid  (pf_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({pf_addr_reg, mem[pf_addr_reg]}),
        .out_valid (fifo_out_valid),
        .out_ready (load_tx),
        .out_data  (fifo_out_data)
    );

    // ************************************************************
    // page buffer and timed programming
    // ************************************************************
    assign in_page   = prog_cnt_reg < PAGE_END;
    assign prog_idx  = prog_cnt_reg[PAGE_W-1:0];
    assign prog_addr = {addr_reg[ADDR_W-1:PAGE_W], prog_idx};
    assign mem_we    = prog_busy_reg && in_page && page_vld[prog_idx] &&
                       !(wp_s && prog_addr[ADDR_W-1:ADDR_W-2] ==
                         `EE_WP_QUAD); // RQ20

    always_comb
    begin
        any_vld = 1'b0;
        for (int i = 0; i < PAGE_N; i++)
        begin
            any_vld = any_vld | page_vld[i];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PAGE_N; gi++)
        begin : g_page
            always_ff @(posedge ref_clk)
            begin
                if (wdat_done && addr_reg[PAGE_W-1:0] == gi)
                begin
                    page_data[gi] <= rx_shift_reg; // RQ8 RQ11
                end
            end

            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    page_vld[gi] <= 1'b0;
                end
                else if (wdat_done && addr_reg[PAGE_W-1:0] == gi)
                begin
                    page_vld[gi] <= 1'b1;
                end
                else if ((prog_busy_reg && prog_cnt_reg == PROG_LAST) ||
                         (!prog_busy_reg && start_det))
                begin
                    page_vld[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prog_busy_reg <= 1'b0;
            prog_cnt_reg  <= '0;
        end
        else if (prog_busy_reg)
        begin
            if (prog_cnt_reg == PROG_LAST)
            begin
                prog_busy_reg <= 1'b0; // RQ7
            end
            prog_cnt_reg <= prog_cnt_reg + 1'b1;
        end
        else if (stop_det && any_vld)
        begin
            prog_busy_reg <= 1'b1; // RQ5 RQ9
            prog_cnt_reg  <= '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (mem_we)
        begin
            mem[prog_addr] <= page_data[prog_idx];
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_nack_mismatch: assert property ( // RQ2
        state_reg == EE_ST_RX && scl_fall && cnt_reg == 4'h8 &&
        role_reg == EE_RL_DEV && !dev_match && !prog_busy_reg
        |=> state_reg == EE_ST_IDLE && !sda_oe_reg)
        else $error("mismatched device byte was acknowledged");
    a_ack_low: assert property ( // RQ2
        state_reg == EE_ST_ACK |-> sda_oe_reg)
        else $error("acknowledge slot not driven low");
    a_busy_deaf: assert property ( // RQ6
        prog_busy_reg ##1 prog_busy_reg |-> !sda_oe_reg &&
        state_reg == EE_ST_IDLE)
        else $error("bus answered during programming");
    a_prog_bound: assert property ( // RQ7
        prog_busy_reg |-> prog_cnt_reg <= PROG_LAST)
        else $error("programming ran past its time");
    a_page_wrap: assert property ( // RQ10
        wdat_done |=> addr_reg[ADDR_W-1:PAGE_W] ==
        $past(addr_reg[ADDR_W-1:PAGE_W]) && addr_reg[PAGE_W-1:0] ==
        PAGE_W'($past(addr_reg[PAGE_W-1:0]) + 1'b1))
        else $error("write address left its page");
    a_read_next: assert property ( // RQ15
        pop |=> addr_reg == ADDR_W'($past(fifo_out_data[FW-1:8]) + 1'b1))
        else $error("read counter did not advance");
    a_addr_form: assert property ( // RQ4
        rx_done && role_reg == EE_RL_ALO |=> addr_reg ==
        {$past(addr_hi_reg), $past(rx_shift_reg)})
        else $error("word address badly formed");
    a_wp_block: assert property ( // RQ20
        wp_s && addr_reg[ADDR_W-1:ADDR_W-2] == `EE_WP_QUAD |-> !mem_we)
        else $error("protected quarter programmed");
    a_stop_prog: assert property ( // RQ5
        !prog_busy_reg && stop_det && any_vld |=> prog_busy_reg)
        else $error("stop after data did not start programming");
    a_stop_release: assert property ( // RQ19
        !prog_busy_reg && stop_det |=> !sda_oe_reg [*2])
        else $error("data still driven after stop");

    c_program: cover property ($rose(prog_busy_reg));
    c_seq_read: cover property (
        state_reg == EE_ST_RACK && scl_fall && more_reg);
    c_poll_busy: cover property (prog_busy_reg && start_det);
    c_page_full: cover property (wdat_done &&
        addr_reg[PAGE_W-1:0] == '1);

endmodule

//--- verification/ee_host_bfm.sv
// host model: two-wire bus master, scl and open-drain data enable
// assumes the bench resolves sda; 160 ns bit period
`timescale 1ns/1ps
module ee_host_bfm (
    output logic      scl,
    output logic      host_oe,
    input  wire logic sda
);
    // ****
    // bus phases, each step one quarter bit
    // ****
    initial
    begin
        scl = 1'b1;
        host_oe = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
    begin
        host_oe = ~b;
        #40 scl = 1'b1;
        #40 r = sda;
        #40 scl = 1'b0;
        #40;
    end
    endtask
    task automatic start();
    begin
        host_oe = 1'b0;
        #40 scl = 1'b1;
        #40 host_oe = 1'b1;
        #40 scl = 1'b0;
        #40;
    end
    endtask
    task automatic stop();
    begin
        host_oe = 1'b1;
        #40 scl = 1'b1;
        #40 host_oe = 1'b0;
        #40;
    end
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
    begin
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, ack);
    end
    endtask
    task automatic get_byte(output logic [7:0] d, input logic last);
        logic r;
    begin
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    end
    endtask
endmodule

//--- verification/testbench.sv
// bench: host model drives the serial memory, array model checks reads
// assumes PROG_CYCLES shortened to 100
`timescale 1ns/1ps
module testbench;
    logic       ref_clk = 1'b0;
    logic       rst_n;
    logic [2:0] straps;
    logic       wp;
    logic       scl;
    logic       host_oe;
    logic       sda_oe;
    logic       sda_o;
    logic       busy;
    logic [7:0] d;
    logic       r;
    wire        sda = host_oe ? 1'b0 : (sda_oe ? sda_o : 1'b1);
    int         mem [8192] = '{default: -1};
    int         ctr;
    int         seed;
    int         bad_count;
    int         checked;
    ee_serial_mem #(.PROG_CYCLES(100)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_o), .sda_oe(sda_oe), .chip_select_straps(straps),
        .write_protect(wp), .prog_busy(busy));
    ee_host_bfm host_u (.scl(scl), .host_oe(host_oe), .sda(sda));
    always #5 ref_clk = ~ref_clk;
    // ****
    // checks and transfers
    // ****
    task automatic chk(input logic [7:0] got, input int exp);
    begin
        checked++;
        if (got !== exp[7:0])
        begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp[7:0]);
        end
    end
    endtask
    task automatic addr_phase(input int a);
    begin
        d = $random(seed);
        host_u.start();
        host_u.put_byte({4'ha, straps, 1'b0}, r);
        chk(r, 0);
        host_u.put_byte({d[7:5], a[12:8]}, r);
        chk(r, 0);
        host_u.put_byte(a[7:0], r);
        chk(r, 0);
    end
    endtask
    task automatic wr(input int a, input int n);
        int i;
    begin
        addr_phase(a);
        for (i = 0; i < n; i++)
        begin
            d = $random(seed);
            host_u.put_byte(d, r);
            chk(r, 0);
            if (!(wp && a >= 16'h1800))
                mem[{a[12:5], 5'(a + i)}] = d;
        end
        ctr = {a[12:5], 5'(a + n)};
        host_u.stop();
        #20;
        if (!wp)
            chk(busy, 1);
        for (i = 0; i < 50; i++)
        begin
            host_u.start();
            host_u.put_byte({4'ha, straps, 1'b0}, r);
            host_u.stop();
            if (r == 1'b0)
                break;
        end
        chk((i < 50) && (wp || i > 0), 1);
    end
    endtask
    task automatic rd(input int a, input int n);
        int i;
    begin
        if (a >= 0)
        begin
            addr_phase(a);
            ctr = a;
        end
        host_u.start();
        host_u.put_byte({4'ha, straps, 1'b1}, r);
        chk(r, 0);
        for (i = 0; i < n; i++)
        begin
            host_u.get_byte(d, i == n - 1);
            if (mem[ctr] >= 0)
                chk(d, mem[ctr]);
            ctr = (ctr + 1) % 8192;
        end
        host_u.stop();
        #20 chk(sda_oe, 0);
    end
    endtask
    task automatic tally_and_finish();
    begin
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    // ****
    // main sequence and watchdog
    // ****
    initial
    begin
        seed = 94;
        rst_n = 1'b0;
        wp = 1'b0;
        bad_count = 0;
        checked = 0;
        straps = $random(seed);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        host_u.start();
        host_u.put_byte({4'ha, ~straps, 1'b0}, r);
        host_u.stop();
        chk(r, 1);
        wr(16'h001e, 34);
        rd(-1, 1);
        rd(16'h0000, 30);
        rd(-1, 2);
        wr(16'h1fff, 1);
        @(negedge ref_clk) wp = 1'b1;
        wr(16'h1fff, 1);
        @(negedge ref_clk) wp = 1'b0;
        rd(16'h1fff, 3);
        tally_and_finish();
    end
    initial
    begin
        #1000000;
        bad_count++;
        tally_and_finish();
    end
endmodule
